// file: dv/udm_panel_model.sv
`timescale 1ns/1ps
// ==========================================
// keyboard knob and terminal inputs
module udm_panel_model (
    input  wire logic pclk,
    output logic      knob_fwd,
    output logic      knob_rev,
    output logic      term_up,
    output logic      term_down
);
    // all sources idle until commanded
    initial begin
        {term_down, term_up, knob_rev, knob_fwd} = 4'h0;
    end

    // independent source levels
    // forward turn is up, reverse is down; levels move only after an edge
    task automatic drive(input logic [3:0] lv, input int n);
        @(posedge pclk);
        {term_down, term_up, knob_rev, knob_fwd} <= lv;
        repeat (n) @(posedge pclk);
        {term_down, term_up, knob_rev, knob_fwd} <= 4'h0;
    endtask
endmodule

// file: dv/updown_offset_and_hour_meters_bench.sv
`timescale 1ns/1ps
`include "udm_consts.svh"
// ==========================================
// signals and instances
module updown_offset_and_hour_meters_bench;
    logic               pclk, presetn, psel, penable, pwrite;
    logic               pready, pslverr, g;
    logic [15:0]        paddr, set_freq;
    logic [31:0]        pwdata, prdata, r, pm0, pm1, t0, t1, t2;
    logic               knob_fwd, knob_rev, term_up, term_down;
    logic               monitor_level0, running, power_fail, nv_load;
    logic               show_set_freq, energy_clear, nv_save;
    logic               restore_req, restore_full;
    logic signed [31:0] nv_ofs, ex, nv_ofs_in;
    logic signed [17:0] freq_out;
    logic [31:0]        rates [3] = '{32'h01F4, 32'h0000, 32'h07D0};
    int                 steps [3] = '{5, 10, 20};
    // rating limits: 0.01 kW, 1 V and 0.1 A units
    int                 rlo [3] = '{40, 60, 1};
    int                 rhi [3] = '{65000, 690, 15000};
    int                 errors, checks_done, n_ecl, n_rst, n_full, n_sav;

    // short tick, hold and minute so the run stays brief
    udm_top #(.TICK_CYC(32'h0000000A), .HOLD_CYC(32'h00000032),
        .MIN_CYC(32'h00000014)) udm_top_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .knob_fwd, .knob_rev, .term_up,
        .term_down, .monitor_level0, .running, .set_freq, .power_fail,
        .nv_load, .nv_ofs_in, .freq_out,
        .show_set_freq, .energy_clear, .restore_req, .restore_full,
        .nv_save, .nv_ofs);
    udm_panel_model udm_panel_model_inst (
        .pclk, .knob_fwd, .knob_rev, .term_up, .term_down);

    initial pclk = 1'b0;
    always #10 pclk = ~pclk;

    // count one-cycle pulses at the edge that samples them
    always @(posedge pclk) begin
        n_ecl  <= n_ecl + int'(energy_clear === 1'b1);
        n_rst  <= n_rst + int'(restore_req === 1'b1);
        n_full <= n_full + int'(restore_full === 1'b1);
        n_sav  <= n_sav + int'(nv_save === 1'b1);
    end

    // ==========================================
    // checking and bus tasks
    task automatic test_done;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp, input string m);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask

    // x compares as not-in-range, so unknowns fail
    task automatic chk_in(input logic signed [31:0] got, input int lo, hi,
                          input string m);
        checks_done++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            errors++;
            $display("MISMATCH %0t %s got %0d", $time, m, got);
        end
    endtask

    // one transfer, held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [13:0] ix,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        e = pslverr;
        if (pready !== 1'b1) begin
            chk(32'h0, 32'h1, "no pready");
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [13:0] ix, input logic [31:0] d,
                      input logic e);
        logic [31:0] x;
        logic        s;
        apb(1'b1, ix, d, x, s);
        chk(32'(s), 32'(e), "slverr");
    endtask

    task automatic rdc(input logic [13:0] ix, input logic [31:0] x);
        logic [31:0] d;
        logic        s;
        apb(1'b0, ix, 32'h0, d, s);
        chk(d, x, "rdata");
    endtask

    // running time in minutes
    task automatic rt(output logic [31:0] t);
        logic [31:0] h, m;
        logic        s;
        apb(1'b0, `UDM_IDX_RH, 32'h0, h, s);
        apb(1'b0, `UDM_IDX_RM, 32'h0, m, s);
        t = h * 32'h3C + m;
    endtask

    // hold sources for ten ticks, settle past sync, check offset change
    task automatic ramp(input logic [3:0] lv, input int lo, hi);
        logic signed [31:0] d;
        logic signed [17:0] f;
        f = freq_out;
        udm_panel_model_inst.drive(lv, 100);
        repeat (8) @(posedge pclk);
        d = freq_out - f;
        chk_in(d, lo, hi, "ramp");
    endtask

    // one-cycle load strobe from storage, then let it settle
    task automatic load(input logic signed [31:0] v);
        nv_ofs_in <= v;
        nv_load <= 1'b1;
        @(posedge pclk);
        nv_load <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    // ==========================================
    // test sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, running, power_fail, nv_load} = 6'h00;
        paddr = 16'h0000;
        pwdata = 32'h0;
        nv_ofs_in = 32'sh00000000;
        monitor_level0 = 1'b1;
        set_freq = 16'h03E8;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(`UDM_IDX_RATE, 32'h01F4);
        rdc(`UDM_IDX_CLR, 32'h0);
        rdc(`UDM_IDX_RET, 32'h1);
        rdc(`UDM_IDX_ECL, 32'h0);
        rdc(`UDM_IDX_RST, 32'h0);
        // rated words in range; rated and version words unmoved by writes
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, `UDM_IDX_RPW + 14'(i), 32'h0, r, g);
            if (i < 3) chk_in(r, rlo[i], rhi[i], "rating");
            wr(`UDM_IDX_RPW + 14'(i), ~r, 1'b1);
            rdc(`UDM_IDX_RPW + 14'(i), r);
        end
        wr(`UDM_IDX_RATE, 32'hC351, 1'b1);
        wr(`UDM_IDX_CLR, 32'h4, 1'b1);
        wr(`UDM_IDX_PVA, 32'h1, 1'b1);
        apb(1'b0, 14'h0C20, 32'h0, r, g);
        chk(r, 32'h0, "unmapped data");
        chk(32'(g), 32'h1, "unmapped err");
        chk(32'(freq_out), 32'h03E8, "base");
        for (int i = 0; i < 3; i++) begin
            wr(`UDM_IDX_RATE, rates[i], 1'b0);
            rdc(`UDM_IDX_RATE, rates[i]);
            ramp(4'h4, 9 * steps[i], 11 * steps[i]);
            chk(32'(show_set_freq), 32'h0, "shown");
        end
        ramp(4'h1, 90, 110);
        chk(32'(show_set_freq), 32'h1, "show");
        repeat (35) @(posedge pclk);
        chk(32'(show_set_freq), 32'h1, "hold");
        repeat (25) @(posedge pclk);
        chk(32'(show_set_freq), 32'h0, "restore");
        monitor_level0 <= 1'b0;
        ramp(4'h2, 0, 0);
        chk(32'(show_set_freq), 32'h0, "gated");
        monitor_level0 <= 1'b1;
        ramp(4'h5, 270, 330);
        // saved value is the offset in 1e-4 Hz units
        ex = (freq_out - $signed({2'b00, set_freq})) * 32'sh64;
        power_fail <= 1'b1;
        @(posedge pclk);
        power_fail <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(32'(n_sav), 32'h1, "save");
        chk(nv_ofs, ex, "saved offset");
        wr(`UDM_IDX_RET, 32'h0, 1'b0);
        ramp(4'h4, 180, 220);
        power_fail <= 1'b1;
        @(posedge pclk);
        power_fail <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(32'(n_sav), 32'h1, "no save");
        r = 32'(freq_out);
        load(32'sh00002710);
        chk(32'(freq_out), r, "no load");
        wr(`UDM_IDX_CLR, 32'h2, 1'b0);
        repeat (6) @(posedge pclk);
        chk(32'(freq_out), 32'h03E8, "clr inact");
        wr(`UDM_IDX_CLR, 32'h3, 1'b0);
        running <= 1'b1;
        ramp(4'h4, 180, 220);
        running <= 1'b0;
        repeat (6) @(posedge pclk);
        chk(32'(freq_out), 32'h03E8, "clr once");
        ramp(4'h4, 180, 220);
        wr(`UDM_IDX_CLR, 32'h1, 1'b0);
        repeat (6) @(posedge pclk);
        chk(32'(freq_out), 32'h03E8, "clr idle");
        wr(`UDM_IDX_CLR, 32'h0, 1'b0);
        set_freq <= 16'h0014;
        repeat (4) @(posedge pclk);
        ramp(4'h8, -20, -20);
        wr(`UDM_IDX_ZC, 32'h1, 1'b0);
        ramp(4'h8, -220, -180);
        wr(`UDM_IDX_ECL, 32'h1, 1'b0);
        wr(`UDM_IDX_ECL, 32'h0, 1'b0);
        repeat (2) @(posedge pclk);
        chk(32'(n_ecl), 32'h1, "energy");
        wr(`UDM_IDX_RST, 32'h1, 1'b0);
        repeat (2) @(posedge pclk);
        chk(32'(n_rst + 16 * n_full), 32'h1, "rst1");
        rdc(`UDM_IDX_RATE, 32'h01F4);
        rdc(`UDM_IDX_RET, 32'h1);
        rdc(`UDM_IDX_ZC, 32'h0);
        wr(`UDM_IDX_RST, 32'h2, 1'b0);
        wr(`UDM_IDX_RST, 32'h3, 1'b1);
        chk(32'(n_rst + 16 * n_full), 32'h12, "rst2");
        // retain is on again: stored 1.00 Hz offset on 0.20 Hz
        load(32'sh00002710);
        chk(32'(freq_out), 32'h00000078, "load");
        apb(1'b0, `UDM_IDX_PM, 32'h0, pm0, g);
        rt(t0);
        running <= 1'b1;
        repeat (200) @(posedge pclk);
        running <= 1'b0;
        repeat (5) @(posedge pclk);
        rt(t1);
        apb(1'b0, `UDM_IDX_PM, 32'h0, pm1, g);
        chk_in(t1 - t0, 9, 11, "run time");
        chk_in((pm1 + 60 - pm0) % 60, 10, 13, "on");
        wr(`UDM_IDX_RM, 32'h0, 1'b1);
        wr(`UDM_IDX_PH, 32'h0, 1'b1);
        repeat (100) @(posedge pclk);
        rt(t2);
        chk(t2, t1, "frozen");
        repeat (1300) @(posedge pclk);
        apb(1'b0, `UDM_IDX_PH, 32'h0, r, g);
        chk_in(r, 1, 10, "hours");
        apb(1'b0, `UDM_IDX_PM, 32'h0, r, g);
        chk_in(r, 0, 59, "minutes");
        test_done;
    end

    // hang guard, well past the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        test_done;
    end
endmodule

// file: include/udm_consts.svh
`ifndef UDM_CONSTS_SVH
`define UDM_CONSTS_SVH
// register word indices, byte address is four times the index
`define UDM_IDX_RATE   14'h0C0A
`define UDM_IDX_CLR    14'h0C0B
`define UDM_IDX_RET    14'h0C0C
`define UDM_IDX_ECL    14'h0C0D
`define UDM_IDX_RST    14'h0C0E
`define UDM_IDX_PH     14'h0C0F
`define UDM_IDX_PM     14'h0C10
`define UDM_IDX_RH     14'h0C11
`define UDM_IDX_RM     14'h0C12
`define UDM_IDX_RPW    14'h0C13
`define UDM_IDX_RV     14'h0C14
`define UDM_IDX_RI     14'h0C15
`define UDM_IDX_PVA    14'h0C16
`define UDM_IDX_PVB    14'h0C17
`define UDM_IDX_FVA    14'h0C18
`define UDM_IDX_FVB    14'h0C19
`define UDM_IDX_KVA    14'h0C1A
`define UDM_IDX_KVB    14'h0C1B
`define UDM_IDX_ZC     14'h0C29
// reset values and limits
`define UDM_RATE_RST   16'h01F4
`define UDM_RATE_MAX   16'hC350
`define UDM_AUTO_RATE  16'h03E8
`define UDM_CLR_RST    2'h0
`define UDM_CLR_IDLE   2'h1
`define UDM_CLR_INACT  2'h2
`define UDM_CLR_ONCE   2'h3
`define UDM_CLR_MAX    32'h00000003
`define UDM_ONE        32'h00000001
`define UDM_RST_FULL   32'h00000002
`define UDM_MIN_MAX    6'h3B
`define UDM_HR_MAX     16'hFFFF
`define UDM_FINE       32'sh00000064
`define UDM_OFS_LIM    32'sh0063FF9C
// input bit positions
`define UDM_KU 0
`define UDM_KD 1
`define UDM_TU 2
`define UDM_TD 3
// times in their own units
`define UDM_CLK_NS     20
`define UDM_TICK_MS    10
`define UDM_MS_PER_CS  10
`define UDM_HOLD_MS    2000
`define UDM_MIN_S      60
`endif

// file: include/udm_pkg.sv
package udm_pkg;
    typedef enum logic [1:0] {
        UDM_NORM = 2'h0,
        UDM_SETF = 2'h1,
        UDM_HOLD = 2'h3
    } udm_disp_e;

    typedef struct packed {
        logic [3:0]         sy1;
        logic [3:0]         sy2;
        logic [3:0]         sy3;
        logic [3:0]         flt;
        logic               rdy;
        logic               err;
        logic [31:0]        rdata;
        logic [15:0]        rate;
        logic [1:0]         copt;
        logic               ret;
        logic               zc;
        logic               ecl;
        logic               rst_req;
        logic               rst_full;
        logic signed [31:0] ofs;
        logic               mod;
        logic               run_d;
        logic [31:0]        tick_cnt;
        logic [31:0]        hold_cnt;
        logic [31:0]        pmin_cnt;
        logic [31:0]        rmin_cnt;
        logic [21:0]        ptime;
        logic [21:0]        rtime;
        udm_disp_e          disp;
        logic               show;
        logic signed [17:0] fout;
        logic               nv_save;
        logic signed [31:0] nv_ofs;
    } udm_state_s;
endpackage

// file: rtl/udm_top.sv
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "udm_consts.svh"
// How it works
// - ramp rate register, zero means automatic rate
// - offset clear option, three clearing modes plus off
// - offset saved at power loss if enabled and modified
// - keyboard and terminal sources act independently
// - keyboard accepted only at monitor level
// - knob shows set frequency, two-second hold
// - terminal ramps at set rate, display unchanged
// - output is set frequency plus offset
// - writing one pulses energy meter clear
// - restore pulse, value two includes motor
// - powered time in hours and minutes
// - running time advances only while running
// - time counters are read only
// - rated power voltage current read only
// - firmware version words read only
// - zero crossing option lets down ramp pass zero
module udm_top #(
    parameter logic [31:0] TICK_CYC =
        32'(`UDM_TICK_MS * 1000000 / `UDM_CLK_NS),
    parameter logic [31:0] HOLD_CYC =
        32'(`UDM_HOLD_MS * 1000000 / `UDM_CLK_NS),
    parameter logic [31:0] MIN_CYC =
        32'((64'(`UDM_MIN_S) * 64'd1000000000) / 64'(`UDM_CLK_NS)),
    // rated and version values below are arbitrary
    parameter logic [15:0] RATED_PW = 16'h00A0,
    parameter logic [15:0] RATED_V  = 16'h017C,
    parameter logic [15:0] RATED_I  = 16'h0028,
    parameter logic [15:0] VER_PA   = 16'h0064,
    parameter logic [15:0] VER_PB   = 16'h03E8,
    parameter logic [15:0] VER_FA   = 16'h0064,
    parameter logic [15:0] VER_FB   = 16'h03E8,
    parameter logic [15:0] VER_KA   = 16'h0064,
    parameter logic [15:0] VER_KB   = 16'h03E8
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [15:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    input  wire logic               knob_fwd,
    input  wire logic               knob_rev,
    input  wire logic               term_up,
    input  wire logic               term_down,
    input  wire logic               monitor_level0,
    input  wire logic               running,
    input  wire logic [15:0]        set_freq,
    input  wire logic               power_fail,
    input  wire logic               nv_load,
    input  wire logic signed [31:0] nv_ofs_in,
    output logic signed [17:0]      freq_out,
    output logic                    show_set_freq,
    output logic                    energy_clear,
    output logic                    restore_req,
    output logic                    restore_full,
    output logic                    nv_save,
    output logic signed [31:0]      nv_ofs
);
    // ========================================
    // helpers
    // offset step in 1e-4 Hz units per tick
    function automatic logic signed [31:0] step(
        input logic [15:0] rt
    );
        return 32'(32'(rt) * `UDM_TICK_MS / `UDM_MS_PER_CS);
    endfunction
    // advance a packed hours/minutes word by a minute
    function automatic logic [21:0] tadv(input logic [21:0] t);
        logic [15:0] h;
        logic [5:0]  m;
        h = t[21:6];
        m = t[5:0];
        if (m != `UDM_MIN_MAX) begin
            m = 6'(m + 6'h1);
        end else if (h != `UDM_HR_MAX) begin
            h = 16'(h + 16'h1);
            m = 6'h0;
        end
        return {h, m};
    endfunction
    // value check per writable register
    function automatic logic wr_ok(
        input logic [13:0] ix,
        input logic [31:0] d
    );
        case (ix)
            `UDM_IDX_RATE: wr_ok = d <= 32'(`UDM_RATE_MAX);
            `UDM_IDX_CLR:  wr_ok = d <= `UDM_CLR_MAX;
            `UDM_IDX_RET,
            `UDM_IDX_ZC,
            `UDM_IDX_ECL:  wr_ok = d <= `UDM_ONE;
            `UDM_IDX_RST:  wr_ok = d <= `UDM_RST_FULL;
            default:       wr_ok = 1'b0;
        endcase
    endfunction
    // ========================================
    // state
    udm_pkg::udm_state_s r_reg;
    udm_pkg::udm_state_s r_next;
    logic [13:0]         idx;
    logic                acc;
    logic                tick;
    logic                ku;
    logic                kd;
    logic                tu;
    logic                td;
    logic                kb_act;
    logic                clr;
    logic [15:0]         trate;
    logic signed [31:0]  delta;
    logic signed [31:0]  osum;
    logic signed [31:0]  floor_v;
    logic signed [31:0]  set_fine;
    logic signed [17:0]  fsum;
    assign idx = paddr[15:2];
    assign acc = psel & penable & r_reg.rdy;
    // ========================================
    // next state
    always_comb begin
        r_next = r_reg;
        // three-stage sync, change taken when stages 2 and 3 agree
        r_next.sy1 = {term_down, term_up, knob_rev, knob_fwd};
        r_next.sy2 = r_reg.sy1;
        r_next.sy3 = r_reg.sy2;
        r_next.flt = (r_reg.sy2 & r_reg.sy3)
                   | (r_reg.flt & (r_reg.sy2 ^ r_reg.sy3));
        ku = monitor_level0 & r_reg.flt[`UDM_KU] & ~r_reg.flt[`UDM_KD];
        kd = monitor_level0 & r_reg.flt[`UDM_KD] & ~r_reg.flt[`UDM_KU];
        tu = r_reg.flt[`UDM_TU] & ~r_reg.flt[`UDM_TD];
        td = r_reg.flt[`UDM_TD] & ~r_reg.flt[`UDM_TU];
        kb_act = ku | kd;
        // apb: one wait state, answer built while pready rises
        r_next.rdy = psel & penable & ~r_reg.rdy;
        r_next.err = 1'b0;
        r_next.rdata = 32'h0;
        if (r_next.rdy) begin
            if (pwrite) begin
                r_next.err = ~wr_ok(idx, pwdata);
            end else begin
                case (idx)
                    `UDM_IDX_RATE: r_next.rdata = 32'(r_reg.rate);
                    `UDM_IDX_CLR:  r_next.rdata = 32'(r_reg.copt);
                    `UDM_IDX_RET:  r_next.rdata = 32'(r_reg.ret);
                    `UDM_IDX_ZC:   r_next.rdata = 32'(r_reg.zc);
                    `UDM_IDX_ECL,
                    `UDM_IDX_RST:  r_next.rdata = 32'h0;
                    `UDM_IDX_PH:   r_next.rdata = 32'(r_reg.ptime[21:6]);
                    `UDM_IDX_PM:   r_next.rdata = 32'(r_reg.ptime[5:0]);
                    `UDM_IDX_RH:   r_next.rdata = 32'(r_reg.rtime[21:6]);
                    `UDM_IDX_RM:   r_next.rdata = 32'(r_reg.rtime[5:0]);
                    `UDM_IDX_RPW:  r_next.rdata = 32'(RATED_PW);
                    `UDM_IDX_RV:   r_next.rdata = 32'(RATED_V);
                    `UDM_IDX_RI:   r_next.rdata = 32'(RATED_I);
                    `UDM_IDX_PVA:  r_next.rdata = 32'(VER_PA);
                    `UDM_IDX_PVB:  r_next.rdata = 32'(VER_PB);
                    `UDM_IDX_FVA:  r_next.rdata = 32'(VER_FA);
                    `UDM_IDX_FVB:  r_next.rdata = 32'(VER_FB);
                    `UDM_IDX_KVA:  r_next.rdata = 32'(VER_KA);
                    `UDM_IDX_KVB:  r_next.rdata = 32'(VER_KB);
                    default:       r_next.err = 1'b1;
                endcase
            end
        end
        // register writes, only on the completing edge
        r_next.ecl = 1'b0;
        r_next.rst_req = 1'b0;
        r_next.rst_full = 1'b0;
        if (acc & pwrite & ~r_reg.err) begin
            case (idx)
                `UDM_IDX_RATE: r_next.rate = pwdata[15:0];
                `UDM_IDX_CLR:  r_next.copt = pwdata[1:0];
                `UDM_IDX_RET:  r_next.ret = pwdata[0];
                `UDM_IDX_ZC:   r_next.zc = pwdata[0];
                `UDM_IDX_ECL:  r_next.ecl = pwdata == `UDM_ONE;
                `UDM_IDX_RST: begin
                    if (pwdata != 32'h0) begin
                        r_next.rst_req = 1'b1;
                        r_next.rst_full = pwdata == `UDM_RST_FULL;
                        r_next.rate = `UDM_RATE_RST;
                        r_next.copt = `UDM_CLR_RST;
                        r_next.ret = 1'b1;
                        r_next.zc = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        tick = r_reg.tick_cnt == TICK_CYC - 32'h1;
        r_next.tick_cnt = tick ? 32'h0 : r_reg.tick_cnt + 32'h1;
        trate = (r_reg.rate == 16'h0) ? `UDM_AUTO_RATE : r_reg.rate;
        delta = 32'sh0;
        if (tick) begin
            if (ku) delta = delta + step(`UDM_AUTO_RATE);
            if (kd) delta = delta - step(`UDM_AUTO_RATE);
            if (tu) delta = delta + step(trate);
            if (td) delta = delta - step(trate);
        end
        osum = r_reg.ofs + delta;
        if (delta != 32'sh0) r_next.mod = 1'b1;
        // floor at zero output unless crossing
        set_fine = $signed({16'h0, set_freq}) * `UDM_FINE;
        floor_v = r_reg.zc ? -`UDM_OFS_LIM : -set_fine;
        if (delta < 32'sh0 && osum < floor_v) osum = floor_v;
        if (osum > `UDM_OFS_LIM) osum = `UDM_OFS_LIM;
        r_next.ofs = osum;
        if (nv_load & r_reg.ret) begin
            r_next.ofs = nv_ofs_in;
            r_next.mod = 1'b0;
        end
        r_next.run_d = running;
        case (r_reg.copt)
            `UDM_CLR_IDLE:  clr = ~running;
            `UDM_CLR_INACT: clr = ~(kb_act | tu | td);
            `UDM_CLR_ONCE:  clr = r_reg.run_d & ~running;
            default:        clr = 1'b0;
        endcase
        if (clr) begin
            r_next.ofs = 32'sh0;
            r_next.mod = 1'b0;
        end
        // save only when enabled and modified
        r_next.nv_save = power_fail & r_reg.ret & r_reg.mod;
        if (r_next.nv_save) begin
            r_next.nv_ofs = r_reg.ofs;
            // a step landing in the save cycle keeps the flag set
            r_next.mod = r_next.mod & (delta != 32'sh0);
        end
        // sum of set frequency and offset
        fsum = 18'($signed({2'b00, set_freq}))
             + 18'(r_next.ofs / `UDM_FINE);
        if (~r_reg.zc && fsum < 18'sh0) fsum = 18'sh0;
        r_next.fout = fsum;
        if (r_reg.pmin_cnt == MIN_CYC - 32'h1) begin
            r_next.pmin_cnt = 32'h0;
            r_next.ptime = tadv(r_reg.ptime);
        end else begin
            r_next.pmin_cnt = r_reg.pmin_cnt + 32'h1;
        end
        // running time, gated by run state
        if (running) begin
            if (r_reg.rmin_cnt == MIN_CYC - 32'h1) begin
                r_next.rmin_cnt = 32'h0;
                r_next.rtime = tadv(r_reg.rtime);
            end else begin
                r_next.rmin_cnt = r_reg.rmin_cnt + 32'h1;
            end
        end
        // display follows knob, holds after stop
        case (r_reg.disp)
            udm_pkg::UDM_NORM: begin
                if (kb_act) r_next.disp = udm_pkg::UDM_SETF;
            end
            udm_pkg::UDM_SETF: begin
                if (!kb_act) begin
                    r_next.disp = udm_pkg::UDM_HOLD;
                    r_next.hold_cnt = 32'h0;
                end
            end
            udm_pkg::UDM_HOLD: begin
                if (kb_act) begin
                    r_next.disp = udm_pkg::UDM_SETF;
                end else if (r_reg.hold_cnt == HOLD_CYC - 32'h1) begin
                    r_next.disp = udm_pkg::UDM_NORM;
                end else begin
                    r_next.hold_cnt = r_reg.hold_cnt + 32'h1;
                end
            end
            default: r_next.disp = udm_pkg::UDM_NORM;
        endcase
        r_next.show = r_next.disp != udm_pkg::UDM_NORM;
    end
    // ========================================
    // registers
    // retain option starts enabled, rate at 5.00 Hz/s
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
            r_reg.rate <= `UDM_RATE_RST;
            r_reg.ret <= 1'b1;
            r_reg.disp <= udm_pkg::UDM_NORM;
        end else begin
            r_reg <= r_next;
        end
    end
    // outputs straight from state
    assign pready = r_reg.rdy;
    assign prdata = r_reg.rdata;
    assign pslverr = r_reg.err;
    assign freq_out = r_reg.fout;
    assign show_set_freq = r_reg.show;
    assign energy_clear = r_reg.ecl;
    assign restore_req = r_reg.rst_req;
    assign restore_full = r_reg.rst_full;
    assign nv_save = r_reg.nv_save;
    assign nv_ofs = r_reg.nv_ofs;
    // ========================================
    // checks
    rate_range_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        r_reg.rate <= `UDM_RATE_MAX)
        else $error("ramp rate out of range");
    clear_idle_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (r_reg.copt == `UDM_CLR_IDLE && !running) |=> r_reg.ofs == 0)
        else $error("offset not cleared while idle");
    no_save_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        nv_save |-> $past(r_reg.ret) && $past(power_fail))
        else $error("offset saved while disabled");
    knob_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!monitor_level0 && !show_set_freq) |=> !show_set_freq)
        else $error("knob accepted outside monitor");
    hold_time_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $fell(show_set_freq) |->
            $past(r_reg.hold_cnt) == HOLD_CYC - 32'h1)
        else $error("display hold time wrong");
    sum_freq_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        r_reg.zc |=> freq_out == 18'($signed({2'b00, $past(set_freq)}))
            + 18'(r_reg.ofs / `UDM_FINE))
        else $error("output not set plus offset");
    energy_pulse_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        energy_clear |-> ##1 !energy_clear)
        else $error("energy clear not a pulse");
    min_range_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        r_reg.ptime[5:0] <= `UDM_MIN_MAX
            && r_reg.rtime[5:0] <= `UDM_MIN_MAX)
        else $error("minutes field out of range");
    run_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !running |=> $stable(r_reg.rtime))
        else $error("running time moved while stopped");
    ro_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (acc && pwrite && idx == `UDM_IDX_PH) |-> pslverr)
        else $error("counter write not refused");
    no_reverse_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !r_reg.zc |=> !freq_out[17])
        else $error("reverse output while prohibited");
endmodule
